// ==== src/ccd_cmd_decoder.sv ====
// What this block does
// - Characters per row is field plus one; above 80 undefined; hretrace 2 to 32 by two.
// - Vertical retrace field gives 1 to 4 rows; rows per frame is field plus one.
// - Lines per row is field plus one; spacing bit selects normal or spaced rows.
// - Underline sits on scan line given by its field plus one.
// - Underline field MSB set blanks top and bottom scan lines of each row.
// - Line counter mode bit: 0 non-offset, 1 offset by one count.
// - Field attribute bit: 0 transparent, 1 non-transparent.
// - Cursor format: blink block, blink underline, steady block, steady underline.
// - Burst gap code 0 gives zero clocks, codes 1 to 7 give 7 to 55.
// - Burst count code gives 1, 2, 4 or 8 DMA cycles per burst.
// - Start command enables interrupts, DMA and video, sets both flags.
// - Stop command disables video, clears video flag, keeps interrupts and retrace.
// - Light pen command returns character then row on next two parameter reads.
// - Cursor command stores next two parameter writes as character then row.
// - Interrupt enable command sets flag; disable command clears it.
// - Commands written with select high, identified by their top three bits.
// - Reset command stops DMA, disables interrupts, blanks video; four bytes follow.
// - New command before the required parameters sets the improper flag.
// - Select high: command write, status read; select low: parameter access.
// - Preset command holds timing counters at top left until another command.
module ccd_cmd_decoder
  import ccd_pkg::*;
#(
  parameter int CHARS_MAX = 80
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_register_select,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_lpen_hit,
  input wire logic [7:0] i_lpen_char,
  input wire logic [7:0] i_lpen_row,
  input wire logic i_last_row_start,
  input wire logic i_dma_underrun,
  input wire logic i_fifo_overrun,
  output logic o_int_enable_flag,
  output logic o_video_on_flag,
  output logic o_video_suppress_out,
  output logic o_dma_enable,
  output logic o_counter_preset,
  output logic [7:0] o_cursor_char,
  output logic [7:0] o_cursor_row,
  output logic [7:0] o_chars_per_row,
  output logic o_chars_undefined,
  output logic o_row_spaced,
  output logic [5:0] o_hretrace_width,
  output logic [2:0] o_retrace_rows,
  output logic [6:0] o_rows_per_frame,
  output logic [4:0] o_lines_per_row,
  output logic [4:0] o_underline_line,
  output logic o_blank_edge_lines,
  output logic o_line_mode_offset,
  output logic o_field_opaque,
  output logic [1:0] o_cursor_format,
  output logic [5:0] o_burst_gap,
  output logic [3:0] o_burst_len
);
  ccd_fmt_if fmt ();

  // The byte-wide row counter cannot flag lengths beyond 128
  if (CHARS_MAX < 1 || CHARS_MAX > 128) begin : g_chk
    $error("CHARS_MAX must lie in 1..128");
  end

  ccd_state_t state_q;
  logic [1:0] idx_q;
  logic ie_q;
  logic ve_q;
  logic dma_q;
  logic vsp_q;
  logic preset_q;
  logic ic_q;
  logic [EVT_FLAGS-1:0] evt_q;
  logic [EVT_FLAGS-1:0] evt_set;
  logic [7:0] cur_char_q;
  logic [7:0] cur_row_q;
  logic [7:0] pen_char_q;
  logic [7:0] pen_row_q;
  logic [7:0] rdata_q;
  logic [2:0] cmd;
  logic cmd_wr;
  logic par_wr;
  logic st_rd;
  logic par_rd;
  logic par_done;
  logic par_step;
  logic [7:0] status_word;

  assign cmd = i_wdata[CMD_MSB:CMD_LSB];
  assign cmd_wr = i_wr & i_register_select;
  assign par_wr = i_wr & ~i_register_select;
  assign st_rd = i_rd & i_register_select;
  assign par_rd = i_rd & ~i_register_select;

  // Parameter accepted by the pending command, and its last one
  always_comb begin
    par_done = 1'b0;
    par_step = 1'b0;
    unique case (state_q)
      CCD_RST: begin
        par_step = par_wr;
        par_done = par_wr && idx_q == RESET_LAST_IDX;
      end
      CCD_CUR: begin
        par_step = par_wr;
        par_done = par_wr && idx_q == PAIR_LAST_IDX;
      end
      CCD_LPEN: begin
        par_step = par_rd;
        par_done = par_rd && idx_q == PAIR_LAST_IDX;
      end
      CCD_IDLE: begin
        par_step = 1'b0;
        par_done = 1'b0;
      end
    endcase
  end

  // Parameter sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= CCD_IDLE;
      idx_q <= 2'h0;
    end else if (cmd_wr) begin
      // A new command always restarts the parameter count
      idx_q <= 2'h0;
      unique case (cmd)
        CMD_RESET: state_q <= CCD_RST;
        CMD_LPEN: state_q <= CCD_LPEN;
        CMD_CURSOR: state_q <= CCD_CUR;
        default: state_q <= CCD_IDLE;
      endcase
    end else if (par_done) begin
      state_q <= CCD_IDLE;
      idx_q <= 2'h0;
    end else if (par_step) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  assign fmt.byte_d = i_wdata;
  assign fmt.byte_idx = idx_q;
  assign fmt.byte_we = par_wr && state_q == CCD_RST;
  assign fmt.start_byte = i_wdata;
  assign fmt.start_we = cmd_wr && cmd == CMD_START;

  ccd_fmt_decode #(
    .CHARS_MAX(CHARS_MAX)
  ) u_fmt (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .f(fmt)
  );

  // Interrupt enable flag
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ie_q <= 1'b0;
    end else if (cmd_wr) begin
      unique case (cmd)
        CMD_START: ie_q <= 1'b1;
        CMD_INT_ON: ie_q <= 1'b1;
        CMD_INT_OFF: ie_q <= 1'b0;
        CMD_RESET: ie_q <= 1'b0;
        default: ie_q <= ie_q;
      endcase
    end
  end

  // Video and DMA; only start turns video back on, as the host must know
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ve_q <= 1'b0;
      dma_q <= 1'b0;
      vsp_q <= 1'b1;
    end else if (cmd_wr) begin
      unique case (cmd)
        CMD_START: begin
          ve_q <= 1'b1;
          dma_q <= 1'b1;
          vsp_q <= 1'b0;
        end
        CMD_STOP: begin
          ve_q <= 1'b0;
          vsp_q <= 1'b1;
        end
        CMD_RESET: begin
          ve_q <= 1'b0;
          dma_q <= 1'b0;
          vsp_q <= 1'b1;
        end
        default: ve_q <= ve_q;
      endcase
    end
  end

  // Counters held at top left; asserted one clock after the command
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      preset_q <= 1'b0;
    end else if (cmd_wr) begin
      preset_q <= cmd == CMD_PRESET;
    end
  end

  // Improper command: too short or too long; a set beats a status read
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ic_q <= 1'b0;
    end else if ((cmd_wr && state_q != CCD_IDLE) || (par_wr && (state_q == CCD_IDLE || state_q == CCD_LPEN))) begin
      ic_q <= 1'b1;
    end else if (st_rd) begin
      ic_q <= 1'b0;
    end
  end

  // Retrace request only counts while interrupts are enabled
  assign evt_set = {i_last_row_start & ie_q, i_lpen_hit, i_dma_underrun, i_fifo_overrun};
  assign status_word = {1'b0, ie_q, evt_q[3], evt_q[2], ic_q, ve_q, evt_q[1], evt_q[0]};

  // Event flags cleared by a status read, set wins
  for (genvar g = 0; g < EVT_FLAGS; g++) begin : g_evt
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        evt_q[g] <= 1'b0;
      end else if (evt_set[g]) begin
        evt_q[g] <= 1'b1;
      end else if (st_rd) begin
        evt_q[g] <= 1'b0;
      end
    end
  end

  // Cursor position
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cur_char_q <= BYTE_RST;
      cur_row_q <= BYTE_RST;
    end else if (par_wr && state_q == CCD_CUR) begin
      if (idx_q == 2'h0) begin
        cur_char_q <= i_wdata;
      end else begin
        cur_row_q <= i_wdata;
      end
    end
  end

  // Pen position, raw; the host applies its own correction
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pen_char_q <= BYTE_RST;
      pen_row_q <= BYTE_RST;
    end else if (i_lpen_hit) begin
      pen_char_q <= i_lpen_char;
      pen_row_q <= i_lpen_row;
    end
  end

  // Read data, one clock after the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_q <= BYTE_RST;
    end else if (st_rd) begin
      rdata_q <= status_word;
    end else if (par_rd) begin
      if (state_q != CCD_LPEN) begin
        rdata_q <= BYTE_RST;
      end else if (idx_q == 2'h0) begin
        rdata_q <= pen_char_q;
      end else begin
        rdata_q <= pen_row_q;
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_int_enable_flag = ie_q;
  assign o_video_on_flag = ve_q;
  assign o_video_suppress_out = vsp_q;
  assign o_dma_enable = dma_q;
  assign o_counter_preset = preset_q;
  assign o_cursor_char = cur_char_q;
  assign o_cursor_row = cur_row_q;
  assign o_chars_per_row = fmt.chars_per_row;
  assign o_chars_undefined = fmt.chars_undefined;
  assign o_row_spaced = fmt.row_spaced;
  assign o_hretrace_width = fmt.hretrace_width;
  assign o_retrace_rows = fmt.retrace_rows;
  assign o_rows_per_frame = fmt.rows_per_frame;
  assign o_lines_per_row = fmt.lines_per_row;
  assign o_underline_line = fmt.underline_line;
  assign o_blank_edge_lines = fmt.blank_edge_lines;
  assign o_line_mode_offset = fmt.line_mode_offset;
  assign o_field_opaque = fmt.field_opaque;
  assign o_cursor_format = fmt.cursor_format;
  assign o_burst_gap = fmt.burst_gap;
  assign o_burst_len = fmt.burst_len;
endmodule : ccd_cmd_decoder

// ==== src/ccd_pkg.sv ====
package ccd_pkg;
  // Command codes, top three bits of a command byte
  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_LPEN = 3'h3;
  localparam logic [2:0] CMD_CURSOR = 3'h4;
  localparam logic [2:0] CMD_INT_ON = 3'h5;
  localparam logic [2:0] CMD_INT_OFF = 3'h6;
  localparam logic [2:0] CMD_PRESET = 3'h7;
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 5;

  // Last parameter byte index per command
  localparam logic [1:0] RESET_LAST_IDX = 2'h3;
  localparam logic [1:0] PAIR_LAST_IDX = 2'h1;

  // Status word bit positions; bit 7 reads as zero
  localparam int ST_IE = 6;
  localparam int ST_IR = 5;
  localparam int ST_LP = 4;
  localparam int ST_IC = 3;
  localparam int ST_VE = 2;
  localparam int ST_DU = 1;
  localparam int ST_FO = 0;
  localparam int EVT_FLAGS = 4;

  // Screen byte 1
  localparam int B1_SPACED = 7;
  // Screen byte 4
  localparam int B4_LINE_MODE = 7;
  localparam int B4_FIELD_MODE = 6;
  // Underline field MSB blanks the top and bottom lines
  localparam int U_BLANK_BIT = 3;

  // Decoded values after reset, equal to all-zero fields
  localparam logic [7:0] CHARS_RST = 8'h01;
  localparam logic [5:0] HRET_RST = 6'h02;
  localparam logic [2:0] VRET_RST = 3'h1;
  localparam logic [6:0] ROWS_RST = 7'h01;
  localparam logic [4:0] LINES_RST = 5'h01;
  localparam logic [4:0] ULINE_RST = 5'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Preset must settle within this many character clocks
  localparam int PRESET_CLKS = 2;

  typedef enum logic [1:0] {
    CCD_IDLE = 2'b00,
    CCD_RST = 2'b01,
    CCD_LPEN = 2'b11,
    CCD_CUR = 2'b10
  } ccd_state_t;
endpackage : ccd_pkg

// ==== src/ccd_fmt_if.sv ====
interface ccd_fmt_if;
  logic [7:0] byte_d;
  logic [1:0] byte_idx;
  logic byte_we;
  logic [7:0] start_byte;
  logic start_we;
  logic [7:0] chars_per_row;
  logic chars_undefined;
  logic row_spaced;
  logic [5:0] hretrace_width;
  logic [2:0] retrace_rows;
  logic [6:0] rows_per_frame;
  logic [4:0] lines_per_row;
  logic [4:0] underline_line;
  logic blank_edge_lines;
  logic line_mode_offset;
  logic field_opaque;
  logic [1:0] cursor_format;
  logic [5:0] burst_gap;
  logic [3:0] burst_len;

  modport ctl (
    output byte_d, byte_idx, byte_we, start_byte, start_we,
    input chars_per_row, chars_undefined, row_spaced, hretrace_width, retrace_rows,
    input rows_per_frame, lines_per_row, underline_line, blank_edge_lines,
    input line_mode_offset, field_opaque, cursor_format, burst_gap, burst_len
  );
  modport dec (
    input byte_d, byte_idx, byte_we, start_byte, start_we,
    output chars_per_row, chars_undefined, row_spaced, hretrace_width, retrace_rows,
    output rows_per_frame, lines_per_row, underline_line, blank_edge_lines,
    output line_mode_offset, field_opaque, cursor_format, burst_gap, burst_len
  );
endinterface : ccd_fmt_if

// ==== src/ccd_fmt_decode.sv ====
module ccd_fmt_decode
  import ccd_pkg::*;
#(
  parameter int CHARS_MAX = 80
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  ccd_fmt_if.dec f
);
  if (CHARS_MAX < 1 || CHARS_MAX > 128) begin : g_chk
    $error("CHARS_MAX must lie in 1..128");
  end

  localparam logic [7:0] CHARS_LIM = 8'(CHARS_MAX);

  // Screen format bytes
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      f.chars_per_row <= CHARS_RST;
      f.chars_undefined <= 1'b0;
      f.row_spaced <= 1'b0;
      f.retrace_rows <= VRET_RST;
      f.rows_per_frame <= ROWS_RST;
      f.lines_per_row <= LINES_RST;
      f.underline_line <= ULINE_RST;
      f.blank_edge_lines <= 1'b0;
      f.line_mode_offset <= 1'b0;
      f.field_opaque <= 1'b0;
      f.cursor_format <= 2'h0;
      f.hretrace_width <= HRET_RST;
    end else if (f.byte_we) begin
      unique case (f.byte_idx)
        2'h0: begin
          f.row_spaced <= f.byte_d[B1_SPACED];
          f.chars_per_row <= {1'b0, f.byte_d[6:0]} + 8'h01;
          // Codes beyond the limit give no defined row length
          f.chars_undefined <= ({1'b0, f.byte_d[6:0]} + 8'h01) > CHARS_LIM;
        end
        2'h1: begin
          f.retrace_rows <= {1'b0, f.byte_d[7:6]} + 3'h1;
          f.rows_per_frame <= {1'b0, f.byte_d[5:0]} + 7'h01;
        end
        2'h2: begin
          f.underline_line <= {1'b0, f.byte_d[7:4]} + 5'h01;
          f.blank_edge_lines <= f.byte_d[4 + U_BLANK_BIT];
          f.lines_per_row <= {1'b0, f.byte_d[3:0]} + 5'h01;
        end
        2'h3: begin
          f.line_mode_offset <= f.byte_d[B4_LINE_MODE];
          f.field_opaque <= f.byte_d[B4_FIELD_MODE];
          f.cursor_format <= f.byte_d[5:4];
          f.hretrace_width <= {1'b0, f.byte_d[3:0], 1'b0} + 6'h02;
        end
      endcase
    end
  end

  // Burst shape from the start command
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      f.burst_gap <= 6'h00;
      f.burst_len <= 4'h1;
    end else if (f.start_we) begin
      f.burst_gap <= (f.start_byte[4:2] == 3'h0) ? 6'h00 : {f.start_byte[4:2], 3'h0} - 6'h01;
      f.burst_len <= 4'h1 << f.start_byte[1:0];
    end
  end
endmodule : ccd_fmt_decode

// ==== dv/ccd_cmd_decoder_checker.sv ====
module ccd_cmd_decoder_checker
  import ccd_pkg::*;
#(
  parameter int CHARS_MAX = 80
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic i_register_select,
  input wire logic [7:0] i_wdata,
  input wire logic o_int_enable_flag,
  input wire logic o_video_on_flag,
  input wire logic o_video_suppress_out,
  input wire logic o_dma_enable,
  input wire logic o_counter_preset,
  input wire logic [7:0] o_chars_per_row,
  input wire logic o_chars_undefined,
  input wire logic [4:0] o_underline_line,
  input wire logic o_blank_edge_lines,
  input wire logic [5:0] o_burst_gap,
  input wire logic [3:0] o_burst_len
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic cw;
  logic start_w;
  logic [2:0] op;
  logic [2:0] gap_code;
  logic [1:0] len_code;
  assign cw = i_wr && i_register_select;
  assign op = i_wdata[CMD_MSB:CMD_LSB];
  assign start_w = cw && op == CMD_START;
  assign gap_code = i_wdata[4:2];
  assign len_code = i_wdata[1:0];
  AST_START: assert property (start_w |=> o_int_enable_flag && o_video_on_flag && o_dma_enable
    && !o_video_suppress_out) else $error("start effects missing");
  AST_GAP: assert property (start_w |=> o_burst_gap == ($past(gap_code) == 3'h0 ? 6'h00
    : {$past(gap_code) - 3'h1, 3'h7})) else $error("burst gap wrong");
  AST_LEN: assert property (start_w |=> o_burst_len == 4'h1 << $past(len_code))
    else $error("burst length wrong");
  AST_VE_SRC: assert property ($rose(o_video_on_flag) |-> $past(start_w))
    else $error("video on without start");
  AST_STOP: assert property (cw && op == CMD_STOP |=> !o_video_on_flag && o_video_suppress_out
    && o_int_enable_flag == $past(o_int_enable_flag)) else $error("stop effects wrong");
  AST_INT_ON: assert property (cw && op == CMD_INT_ON |=> o_int_enable_flag)
    else $error("interrupt enable not set");
  AST_INT_OFF: assert property (cw && op == CMD_INT_OFF |=> !o_int_enable_flag)
    else $error("interrupt enable not cleared");
  AST_RST_CMD: assert property (cw && op == CMD_RESET |=> !o_int_enable_flag && !o_dma_enable
    && o_video_suppress_out && !o_video_on_flag) else $error("reset command effects wrong");
  AST_PRESET: assert property (cw && op == CMD_PRESET |-> ##[1:2] o_counter_preset)
    else $error("preset late");
  AST_PRESET_HOLD: assert property (o_counter_preset && !cw |=> o_counter_preset)
    else $error("preset dropped early");
  AST_UNDEF: assert property (o_chars_undefined == (o_chars_per_row > CHARS_MAX))
    else $error("undefined width flag wrong");
  AST_BLANK: assert property (o_blank_edge_lines == (o_underline_line > 5'h08))
    else $error("edge blanking wrong");
  C_START: cover property (start_w ##1 o_video_on_flag);
  C_STOP: cover property (cw && op == CMD_STOP);
  C_PRESET: cover property (o_counter_preset [*4]);
endmodule : ccd_cmd_decoder_checker

// ==== dv/ccd_host_model.sv ====
module ccd_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_register_select,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_register_select = 1'b0;
    o_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic put(input logic rs, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr = 1'b1;
    o_register_select = rs;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_register_select = ~rs;
    o_wdata = ~d;
  endtask : put
  // Pen position is handed back raw; the host corrects it in software
  task automatic get(input logic rs, output logic [7:0] q);
    @(posedge i_clk);
    #1;
    o_rd = 1'b1;
    o_register_select = rs;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_register_select = ~rs;
    q = i_rdata;
  endtask : get
endmodule : ccd_host_model

// ==== dv/ccd_cmd_decoder_test.sv ====
module ccd_cmd_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CHARS_MAX = 80;
  logic clk, nrst, wr, rd, rs, hit, lrs, dur, fov, ie, ve, video_suppress_out, dma, pre, und, spc, blk, lmo, fop;
  logic [7:0] wd, rdat, pch, prow, cch, crow, cpr, q, b1, b2, b3, b4;
  logic [5:0] hret, gap;
  logic [2:0] vret;
  logic [6:0] rows;
  logic [4:0] lines, ul;
  logic [1:0] cfmt;
  logic [3:0] blen;
  int n_errors, n_tests;
  logic [7:0] cfg [4][4] = '{'{8'h4F, 8'hFF, 8'hFF, 8'hFF}, '{8'hD0, 8'h00, 8'h70, 8'h50},
    '{8'h00, 8'h80, 8'h0F, 8'hA7}, '{8'h7F, 8'h41, 8'h8A, 8'h0C}};
  ccd_host_model u_ccd_host_model (.i_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
    .o_register_select(rs), .o_wdata(wd));
  ccd_cmd_decoder #(.CHARS_MAX(CHARS_MAX)) u_ccd_cmd_decoder (.i_clk(clk), .i_nrst(nrst), .i_wr(wr),
    .i_rd(rd), .i_register_select(rs), .i_wdata(wd), .o_rdata(rdat), .i_lpen_hit(hit), .i_lpen_char(pch),
    .i_lpen_row(prow), .i_last_row_start(lrs), .i_dma_underrun(dur), .i_fifo_overrun(fov),
    .o_int_enable_flag(ie), .o_video_on_flag(ve), .o_video_suppress_out(video_suppress_out), .o_dma_enable(dma),
    .o_counter_preset(pre), .o_cursor_char(cch), .o_cursor_row(crow), .o_chars_per_row(cpr),
    .o_chars_undefined(und), .o_row_spaced(spc), .o_hretrace_width(hret), .o_retrace_rows(vret),
    .o_rows_per_frame(rows), .o_lines_per_row(lines), .o_underline_line(ul), .o_blank_edge_lines(blk),
    .o_line_mode_offset(lmo), .o_field_opaque(fop), .o_cursor_format(cfmt), .o_burst_gap(gap),
    .o_burst_len(blen));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] d);
    u_ccd_host_model.put(1'b1, d);
  endtask : cmd
  task automatic status(input logic [7:0] exp);
    u_ccd_host_model.get(1'b1, q);
    chk(q, exp);
  endtask : status
  task automatic pulse_events();
    @(posedge clk);
    #1;
    {lrs, dur, fov} = 3'h7;
    @(posedge clk);
    #1;
    {lrs, dur, fov} = 3'h0;
  endtask : pulse_events
  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    {nrst, hit, lrs, dur, fov} = 5'h00;
    pch = 8'h00;
    prow = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({video_suppress_out, dma, ie, ve}, 8'h08);
    chk({cpr, 2'b00, hret, 5'h00, vret, 1'b0, rows}, {8'h01, 8'h02, 8'h01, 8'h01});
    chk({lines, blen}, {5'h01, 4'h1});
    chk(rdat, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cmd({3'b001, 3'(i), 2'(i)});
      chk(gap, 8'(i == 0 ? 0 : 8 * i - 1));
      chk(blen, 8'(1 << (i % 4)));
      chk({ie, ve, dma, video_suppress_out}, 8'h0E);
    end
    for (int i = 0; i < 4; i++) begin
      {b1, b2, b3, b4} = {cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3]};
      cmd(8'h00);
      for (int j = 0; j < 4; j++) u_ccd_host_model.put(1'b0, cfg[i][j]);
      chk(cpr, 8'(b1[6:0]) + 8'h01);
      chk(und, 8'((8'(b1[6:0]) + 8'h01) > CHARS_MAX));
      chk(hret, 8'({b4[3:0], 1'b0}) + 8'h02);
      chk(vret, 8'(b2[7:6]) + 8'h01);
      chk(rows, 8'(b2[5:0]) + 8'h01);
      chk({lines, spc}, {8'(b3[3:0]) + 8'h01, b1[7]});
      chk(ul, 8'(b3[7:4]) + 8'h01);
      chk(blk, b3[7]);
      chk(lmo, b4[7]);
      chk(fop, b4[6]);
      chk(cfmt, b4[5:4]);
      chk({ie, ve, dma, video_suppress_out}, 8'h01);
    end
    cmd(8'h20);
    cmd(8'h40);
    chk({ie, ve, dma, video_suppress_out}, 8'h0B);
    cmd(8'hC0);
    chk(ie, 8'h00);
    cmd(8'hBF);
    chk({ie, ve}, 8'h02);
    cmd(8'h20);
    chk(ve, 8'h01);
    status(8'h44);
    cmd(8'h80);
    u_ccd_host_model.put(1'b0, 8'h12);
    u_ccd_host_model.put(1'b0, 8'h34);
    chk(cch, 8'h12);
    chk(crow, 8'h34);
    status(8'h44);
    @(posedge clk);
    #1;
    {hit, pch, prow} = {1'b1, 8'h2A, 8'h15};
    @(posedge clk);
    #1;
    {hit, pch, prow} = {1'b0, 8'hD5, 8'hEA};
    status(8'h54);
    cmd(8'h60);
    u_ccd_host_model.get(1'b0, q);
    chk(q, 8'h2A);
    u_ccd_host_model.get(1'b0, q);
    chk(q, 8'h15);
    status(8'h44);
    u_ccd_host_model.get(1'b0, q);
    chk(q, 8'h00);
    cmd(8'h80);
    u_ccd_host_model.put(1'b0, 8'h55);
    cmd(8'hA0);
    status(8'h4C);
    status(8'h44);
    u_ccd_host_model.put(1'b0, 8'h01);
    status(8'h4C);
    pulse_events();
    status(8'h67);
    cmd(8'hE0);
    for (int n = 0; n < 2 && pre !== 1'b1; n++) @(posedge clk);
    chk(pre, 8'h01);
    repeat (6) @(posedge clk);
    #1;
    chk(pre, 8'h01);
    cmd(8'hA0);
    chk(pre, 8'h00);
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({video_suppress_out, dma, ie, ve}, 8'h08);
    chk({cpr, 2'b00, hret, 5'h00, vret, 1'b0, rows}, {8'h01, 8'h02, 8'h01, 8'h01});
    chk({cch, crow, rdat}, 24'h00_0000);
    report_and_stop();
  end
endmodule : ccd_cmd_decoder_test
bind ccd_cmd_decoder ccd_cmd_decoder_checker #(.CHARS_MAX(CHARS_MAX)) u_ccd_cmd_decoder_checker (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_register_select(i_register_select), .i_wdata(i_wdata),
  .o_int_enable_flag(o_int_enable_flag), .o_video_on_flag(o_video_on_flag),
  .o_video_suppress_out(o_video_suppress_out), .o_dma_enable(o_dma_enable), .o_counter_preset(o_counter_preset),
  .o_chars_per_row(o_chars_per_row), .o_chars_undefined(o_chars_undefined), .o_underline_line(o_underline_line),
  .o_blank_edge_lines(o_blank_edge_lines), .o_burst_gap(o_burst_gap), .o_burst_len(o_burst_len));
